// >>> core/ext_mem_pkg.sv
package ext_mem_pkg;

	// register byte addresses on the plain register port
	localparam logic [7:0] ADDR_FORMAT_CFG = 8'hF5;
	localparam logic [7:0] ADDR_TIMING_CFG = 8'hF6;
	localparam logic [7:0] ADDR_WAIT_CTRL  = 8'hFC;

	// reset values
	localparam logic [7:0] RST_FORMAT_CFG = 8'h80;
	localparam logic [7:0] RST_TIMING_CFG = 8'h1F;
	localparam logic [7:0] RST_WAIT_CTRL  = 8'h7F;

	// writable bit masks; other bits keep their reset value
	localparam logic [7:0] MASK_FORMAT_CFG = 8'h76;
	localparam logic [7:0] MASK_TIMING_CFG = 8'h7F;
	localparam logic [7:0] MASK_WAIT_CTRL  = 8'h7F;

	// format register fields
	localparam int FMT_BUS_FORMAT  = 6;
	localparam int FMT_SECOND_DS   = 5;
	localparam int FMT_AS_ALTFUNC  = 4;
	localparam int FMT_EXT_TOGGLE  = 2;
	localparam int FMT_DRIVE_SIZE  = 1;

	// timing register fields
	localparam int TIM_CS_SAVE     = 6;
	localparam int TIM_PAGE_REMAP  = 5;
	localparam int TIM_LAS_LSB     = 2;
	localparam int TIM_UAS_LSB     = 0;

	// wait control fields
	localparam int WC_WATCHDOG     = 6;
	localparam int WC_UDS_LSB      = 3;
	localparam int WC_LDS_LSB      = 0;

	// upper block select address bit
	localparam int ADDR_BLOCK_BIT  = 21;

	localparam logic [2:0] ZERO3   = 3'h0;
	localparam logic [2:0] ONE3    = 3'h1;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        internal;
		logic [21:0] addr;
		logic [7:0]  wdata;
	} mem_req_t;

	typedef struct packed {
		logic        addr_strobe_n;
		logic        data_strobe_n;
		logic        second_data_strobe_n;
		logic        rw_n;
		logic        addr_strobe_oe;
		logic [7:0]  ad_out;
		logic        ad_oe;
		logic [21:8] addr_hi;
	} mem_pins_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_ADDR = 4'h2,
		ST_DATA = 4'h4,
		ST_DONE = 4'h8
	} cyc_state_t;

endpackage

// >>> core/external_memory_bus_config.sv
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
// What this block does
// - format bit turns address strobe into latch enable
// - latch format: data strobe drops on reads and on writes alike
// - latch format: read/write is write enable, drive data
// - second strobe off: main strobe always, second high
// - second strobe on: lower uses second, upper uses main
// - address strobe alternate function follows its bit
// - toggle off: internal accesses move no pins beyond returning address strobe and latch-format rw to idle
// - toggle on: internal accesses toggle, main strobe not
// - drive size bit selects high-drive buffers
// - save bit clear: push pc and flags only
// - save bit set: push and restore code segment
// - remap bit swaps page registers with port data
// - lower address strobe stretch zero to three
// - upper address strobe stretch zero to three
// - upper data strobe stretch zero to seven
// - lower data strobe stretch zero to seven
// - data strobe waits count internal clock cycles
module external_memory_bus_config (
	// clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  sys_rst,
	// register port
	input  wire logic [7:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic [7:0]                 reg_rdata,
	// cpu memory request
	input  wire ext_mem_pkg::mem_req_t mem_req,
	output logic                       mem_busy,
	output logic                       mem_done,
	output logic [7:0]                 mem_rdata,
	// memory bus pins
	input  wire logic [7:0]            ad_in,
	output ext_mem_pkg::mem_pins_t     pins,
	// configuration outputs to cpu and ports
	output logic                       high_drive_sel,
	output logic                       code_segment_save_enable,
	output logic                       page_register_remap,
	output logic                       watchdog_enable
);
	import ext_mem_pkg::*;

	typedef struct packed {
		logic [7:0]  fmt;
		logic [7:0]  tim;
		logic [7:0]  wait_state_control;
		logic [7:0]  rdata;
		cyc_state_t  st;
		logic [2:0]  cnt;
		logic        lat_format;
		logic        lat_ds2;
		logic        lat_upper;
		logic        lat_ext;
		logic        lat_pins;
		logic        lat_write;
		logic [2:0]  lat_dwait;
		logic [7:0]  lat_wdata;
		logic [7:0]  mrdata;
		logic        done;
		mem_pins_t   pins;
	} state_t;

	state_t state_ff;
	state_t nxt_state;

	// one combinational pass computes the whole next state
	always_comb begin
		logic       upper;
		logic [2:0] await_cnt;
		logic       main_ds;
		upper = 1'b0;
		await_cnt = ZERO3;
		main_ds = 1'b0;
		nxt_state = state_ff;
		nxt_state.done = 1'b0;
		nxt_state.rdata = 8'h00;

		// register writes; read-only bits stay at reset value
		if (reg_wr) begin
			unique case (reg_addr)
			ADDR_FORMAT_CFG: nxt_state.fmt = (reg_wdata & MASK_FORMAT_CFG)
				| (RST_FORMAT_CFG & ~MASK_FORMAT_CFG);
			ADDR_TIMING_CFG: nxt_state.tim = (reg_wdata & MASK_TIMING_CFG)
				| (RST_TIMING_CFG & ~MASK_TIMING_CFG);
			ADDR_WAIT_CTRL: nxt_state.wait_state_control = reg_wdata & MASK_WAIT_CTRL;
			default: ;
			endcase
		end
		// reads answer one cycle later; unmapped reads give zero
		if (reg_rd) begin
			unique case (reg_addr)
			ADDR_FORMAT_CFG: nxt_state.rdata = state_ff.fmt;
			ADDR_TIMING_CFG: nxt_state.rdata = state_ff.tim;
			ADDR_WAIT_CTRL: nxt_state.rdata = state_ff.wait_state_control;
			default: nxt_state.rdata = 8'h00;
			endcase
		end

		// alternate function enable tracks its bit at all times
		nxt_state.pins.addr_strobe_oe = state_ff.fmt[FMT_AS_ALTFUNC];

		// main data strobe for this cycle's block and second strobe mode
		main_ds = !(state_ff.lat_ds2 && !state_ff.lat_upper);

		unique case (state_ff.st)
		ST_IDLE: begin
			if (mem_req.valid) begin
				// freeze settings so a register write mid-cycle is harmless
				upper = mem_req.addr[ADDR_BLOCK_BIT];
				nxt_state.lat_format = state_ff.fmt[FMT_BUS_FORMAT];
				nxt_state.lat_ds2 = state_ff.fmt[FMT_SECOND_DS];
				nxt_state.lat_upper = upper;
				nxt_state.lat_ext = !mem_req.internal;
				// internal cycles drive pins only with toggle set; otherwise they only return address strobe and latch-format rw to idle
				nxt_state.lat_pins = !mem_req.internal
					|| state_ff.fmt[FMT_EXT_TOGGLE];
				nxt_state.lat_write = mem_req.write;
				nxt_state.lat_wdata = mem_req.wdata;
				await_cnt = upper
					? {1'b0, state_ff.tim[TIM_UAS_LSB +: 2]}
					: {1'b0, state_ff.tim[TIM_LAS_LSB +: 2]};
				// internal-clock counts, this block's only clock
				nxt_state.lat_dwait = upper
					? state_ff.wait_state_control[WC_UDS_LSB +: 3]
					: state_ff.wait_state_control[WC_LDS_LSB +: 3];
				nxt_state.cnt = await_cnt;
				nxt_state.st = ST_ADDR;
				if (nxt_state.lat_pins) begin
					// latch enable is active high, standard strobe low
					nxt_state.pins.addr_strobe_n =
						state_ff.fmt[FMT_BUS_FORMAT];
					nxt_state.pins.ad_out = mem_req.addr[7:0];
					nxt_state.pins.ad_oe = 1'b1;
					nxt_state.pins.addr_hi = mem_req.addr[21:8];
					// standard format: rw level set for the whole cycle
					nxt_state.pins.rw_n = state_ff.fmt[FMT_BUS_FORMAT]
						? 1'b1 : !mem_req.write;
				end
			end
		end
		ST_ADDR: begin
			if (state_ff.cnt != ZERO3) begin
				nxt_state.cnt = state_ff.cnt - ONE3;
			end else begin
				// end of address phase: latch captures address here
				nxt_state.pins.addr_strobe_n =
					!state_ff.lat_format;
				nxt_state.cnt = state_ff.lat_dwait;
				nxt_state.st = ST_DATA;
				if (state_ff.lat_pins) begin
					nxt_state.pins.ad_oe = state_ff.lat_write;
					nxt_state.pins.ad_out = state_ff.lat_wdata;
					if (state_ff.lat_format && state_ff.lat_write) begin
						nxt_state.pins.rw_n = 1'b0;
					end
					// main strobe stays high on internal accesses
					if (main_ds && state_ff.lat_ext) begin
						nxt_state.pins.data_strobe_n = 1'b0;
					end
					if (!main_ds) begin
						nxt_state.pins.second_data_strobe_n = 1'b0;
					end
				end
			end
		end
		ST_DATA: begin
			if (state_ff.cnt != ZERO3) begin
				nxt_state.cnt = state_ff.cnt - ONE3;
			end else begin
				// strobe rise: read data sampled, write data taken
				nxt_state.pins.data_strobe_n = 1'b1;
				nxt_state.pins.second_data_strobe_n = 1'b1;
				if (state_ff.lat_format) begin
					nxt_state.pins.rw_n = 1'b1;
				end
				if (!state_ff.lat_write && state_ff.lat_ext) begin
					nxt_state.mrdata = ad_in;
				end
				nxt_state.st = ST_DONE;
			end
		end
		ST_DONE: begin
			// write data held until next address goes out
			nxt_state.done = 1'b1;
			nxt_state.st = ST_IDLE;
		end
		endcase

		if (sys_rst) begin
			nxt_state = '0;
			nxt_state.fmt = RST_FORMAT_CFG;
			nxt_state.tim = RST_TIMING_CFG;
			nxt_state.wait_state_control = RST_WAIT_CTRL;
			nxt_state.st = ST_IDLE;
			nxt_state.pins.addr_strobe_n = 1'b1;
			nxt_state.pins.data_strobe_n = 1'b1;
			nxt_state.pins.second_data_strobe_n = 1'b1;
			nxt_state.pins.rw_n = 1'b1;
		end
	end

	// single state register
	always_ff @(posedge ref_clk) begin
		state_ff <= nxt_state;
	end

	// outputs come straight from the state register
	assign reg_rdata = state_ff.rdata;
	assign mem_busy = (state_ff.st != ST_IDLE);
	assign mem_done = state_ff.done;
	assign mem_rdata = state_ff.mrdata;
	assign pins = state_ff.pins;
	assign high_drive_sel = state_ff.fmt[FMT_DRIVE_SIZE];
	// the cpu stacks by these two bits; software keeps select bits legal
	assign code_segment_save_enable = state_ff.tim[TIM_CS_SAVE];
	assign page_register_remap = state_ff.tim[TIM_PAGE_REMAP];
	assign watchdog_enable = state_ff.wait_state_control[WC_WATCHDOG];

endmodule

// >>> tb/ext_mem_props.sv
`timescale 1ns/1ps
module ext_mem_props (
	// clock and reset
	input logic                  ref_clk,
	input logic                  sys_rst,
	// register port and cpu side
	input logic [7:0]            reg_addr,
	input logic [7:0]            reg_wdata,
	input logic                  reg_wr,
	input ext_mem_pkg::mem_req_t mem_req,
	input logic                  mem_busy,
	input logic                  mem_done,
	// pins and configuration bits
	input ext_mem_pkg::mem_pins_t pins,
	input logic                  high_drive_sel,
	input logic                  code_segment_save_enable,
	input logic                  page_register_remap
);
	import ext_mem_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	logic wf, wt, dsl;
	// two cycles allow for a registered pin stage after the register
	assign wf = reg_wr && reg_addr == ADDR_FORMAT_CFG;
	assign wt = reg_wr && reg_addr == ADDR_TIMING_CFG;
	assign dsl = !(pins.data_strobe_n && pins.second_data_strobe_n);
	property p_alt;
		wf |-> ##2 pins.addr_strobe_oe == $past(reg_wdata[4], 2);
	endproperty
	a_alt: assert property (p_alt) else $error("alt func wrong");
	property p_drv;
		wf |-> ##2 high_drive_sel == $past(reg_wdata[1], 2);
	endproperty
	a_drv: assert property (p_drv) else $error("drive size wrong");
	property p_cs;
		wt |-> ##2 code_segment_save_enable == $past(reg_wdata[6], 2);
	endproperty
	a_cs: assert property (p_cs) else $error("cs save wrong");
	property p_remap;
		wt |-> ##2 page_register_remap == $past(reg_wdata[5], 2);
	endproperty
	a_remap: assert property (p_remap) else $error("remap wrong");
	property p_one_ds;
		!(!pins.data_strobe_n && !pins.second_data_strobe_n);
	endproperty
	a_one_ds: assert property (p_one_ds) else $error("two strobes");
	property p_int;
		mem_busy && mem_req.internal |-> pins.data_strobe_n;
	endproperty
	a_int: assert property (p_int) else $error("ds on internal");
	property p_wr;
		!pins.rw_n && dsl |-> pins.ad_oe;
	endproperty
	a_wr: assert property (p_wr) else $error("write not driven");
	property p_rd;
		pins.rw_n && dsl |-> !pins.ad_oe;
	endproperty
	a_rd: assert property (p_rd) else $error("read bus driven");
	property p_len;
		$rose(mem_busy) |-> mem_busy [*3] ##[1:11] mem_done;
	endproperty
	a_len: assert property (p_len) else $error("cycle length");
	c_wr: cover property (mem_done && mem_req.write);
	c_int: cover property (mem_done && mem_req.internal);
	c_ds2: cover property (!pins.second_data_strobe_n);
endmodule
bind external_memory_bus_config ext_mem_props chk_u (.ref_clk(ref_clk),
	.sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .mem_req(mem_req), .mem_busy(mem_busy),
	.mem_done(mem_done), .pins(pins), .high_drive_sel(high_drive_sel),
	.code_segment_save_enable(code_segment_save_enable),
	.page_register_remap(page_register_remap));

// >>> tb/ext_mem_partner.sv
`timescale 1ns/1ps
module ext_mem_partner (
	// clock and bus format
	input logic                   ref_clk,
	input logic                   latch_fmt,
	// device pins
	input ext_mem_pkg::mem_pins_t pins,
	output logic [7:0]            ad_in
);
	import ext_mem_pkg::*;
	logic [7:0] mem [int];
	logic [7:0] lo_addr = 8'h00;
	logic [7:0] held = 8'h00;
	mem_pins_t  pq = '1;
	logic       as_on, dsl, dsw;
	int         key;
	assign key = int'({pins.addr_hi, lo_addr});
	assign as_on = latch_fmt ? pins.addr_strobe_n : !pins.addr_strobe_n;
	assign dsl = !(pins.data_strobe_n && pins.second_data_strobe_n);
	assign dsw = !(pq.data_strobe_n && pq.second_data_strobe_n);
	// no pull-up on the bus: released lines show the inverted stale byte
	always_comb ad_in = (dsl && pins.rw_n && mem.exists(key)) ? mem[key] : ~held;
	// latch follows the bus while the strobe is active, keeps it after
	always @(posedge ref_clk) begin
		pq <= pins;
		held <= ad_in;
		if (as_on && pins.ad_oe) lo_addr <= pins.ad_out;
		if (dsw && !dsl && !pq.rw_n) mem[key] = pq.ad_out;
	end
endmodule

// >>> tb/external_memory_bus_config_bench.sv
`timescale 1ns/1ps
module external_memory_bus_config_bench;
	import ext_mem_pkg::*;
	logic       ref_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, mem_rdata;
	logic [7:0] ad_in, w, t, c, d;
	logic       mem_busy, mem_done, fmt = 1'b0;
	logic [21:0] a;
	mem_req_t   mem_req = '0;
	mem_pins_t  pins;
	int         num_errors = 0, n_tests = 0, len;
	logic [7:0] ref_mem [int];
	external_memory_bus_config dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req),
		.mem_busy(mem_busy), .mem_done(mem_done), .mem_rdata(mem_rdata),
		.ad_in(ad_in), .pins(pins), .high_drive_sel(),
		.code_segment_save_enable(), .page_register_remap(),
		.watchdog_enable());
	ext_mem_partner mem_u (.ref_clk(ref_clk), .latch_fmt(fmt), .pins(pins),
		.ad_in(ad_in));
	initial forever #2 ref_clk = ~ref_clk;
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t byte %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_len(input int got, input int exp);
		n_tests++;
		if (got != exp) begin
			num_errors++;
			$display("[ERR] %0t length %0d expected %0d", $time, got, exp);
		end
	endtask
	task automatic reg_write(input logic [7:0] ad, input logic [7:0] dv);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= dv;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic reg_check(input logic [7:0] ad, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk8(reg_rdata, exp);
	endtask
	// request held until done, dropped before the next edge
	task automatic mem_run(input logic wr, input logic intl, input int exp);
		int n;
		n = 0;
		@(posedge ref_clk);
		mem_req <= '{1'b1, wr, intl, a, d};
		do begin
			@(posedge ref_clk);
			#1 n++;
		end while (mem_done !== 1'b1 && n < 40);
		mem_req.valid <= 1'b0;
		if (n >= 40) begin
			num_errors++;
			$display("[ERR] %0t memory cycle never finished", $time);
		end
		if (exp > 0) chk_len(n, exp);
		if (!wr && !intl) chk8(mem_rdata, ref_mem[a]);
		if (wr && !intl) ref_mem[a] = d;
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// watchdog: the full run needs a few microseconds
	initial begin
		#40000;
		num_errors++;
		tally_and_finish;
	end
	initial begin
		void'($urandom(61));
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		reg_check(ADDR_FORMAT_CFG, RST_FORMAT_CFG);
		reg_check(ADDR_TIMING_CFG, RST_TIMING_CFG);
		reg_check(ADDR_WAIT_CTRL, RST_WAIT_CTRL);
		reg_check(8'h10, 8'h00);
		$display("test reset done");
		// every format and strobe routing mode, random stretches
		for (int m = 0; m < 4; m++) begin
			w = 8'($urandom) & 8'h16 | {1'b0, 2'(m), 5'h00};
			reg_write(ADDR_FORMAT_CFG, w);
			fmt <= w[6];
			reg_check(ADDR_FORMAT_CFG, RST_FORMAT_CFG | w & MASK_FORMAT_CFG);
			t = 8'($urandom) & 8'h6F | 8'h10;
			reg_write(ADDR_TIMING_CFG, t);
			reg_check(ADDR_TIMING_CFG, t & MASK_TIMING_CFG);
			c = 8'($urandom) & 8'h3F | 8'h40;
			reg_write(ADDR_WAIT_CTRL, c);
			reg_check(ADDR_WAIT_CTRL, c & MASK_WAIT_CTRL);
			for (int k = 0; k < 4; k++) begin
				a = {k[0], 21'($urandom)};
				d = 8'($urandom);
				len = 4 + (k[0] ? t[1:0] + c[5:3] : t[3:2] + c[2:0]);
				mem_run(1'b1, 1'b0, len);
				mem_run(1'b0, 1'b0, len);
			end
			mem_run(1'b0, 1'b1, len);
			$display("test mode %0d done", m);
		end
		tally_and_finish;
	end
endmodule
